// File: src/tone_device.sv
`timescale 1ns/1ps
`default_nettype none
module tone_device
    import tone_bus_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    tone_bus_if.device       bus,
    input  wire logic        logic_input,
    input  wire logic        timer_expired,
    input  wire logic        silence_expired,
    input  wire logic        measure_done,
    input  wire logic [15:0] measured_freq,
    output logic             audio_switch,
    output logic             summing_switch,
    output logic [1:0]       band_select,
    output logic [7:0]       silence_period,
    output logic [15:0]      tone_one,
    output logic [15:0]      tone_two,
    output logic [7:0]       timer_period,
    output logic             timer_reload
);
    import tone_bus_pkg::*;

    ////////////////////////////////////////////////////////////////
    logic [1:0] sck_s, sel_s, din_s, lin_s;
    logic       sck_d;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_s <= 2'h0;
            sel_s <= 2'h3;
            din_s <= 2'h0;
            lin_s <= 2'h0;
            sck_d <= 1'b0;
        end else if (clk_en) begin
            sck_s <= {sck_s[0], bus.serial_clock};
            sel_s <= {sel_s[0], bus.select_n};
            din_s <= {din_s[0], bus.cmd_data};
            lin_s <= {lin_s[0], logic_input};
            sck_d <= sck_s[1];
        end
    end
    wire logic rise   = sck_s[1] & ~sck_d;
    wire logic fall   = ~sck_s[1] & sck_d;
    wire logic active = ~sel_s[1];

    ////////////////////////////////////////////////////////////////
    logic [7:0]  shift;
    logic [2:0]  bit_cnt;
    logic [1:0]  byte_cnt;
    logic [7:0]  cmd;
    logic [7:0]  first_byte;
    logic [15:0] reply_shift;
    logic [7:0]  control;
    logic [2:0]  flags;
    wire logic [7:0] next_byte = {shift[6:0], din_s[1]};
    wire logic byte_done = active && rise && bit_cnt == 3'h7;
    wire logic [7:0] status_byte = {4'h0, lin_s[1], flags};

    function automatic logic is_read(input logic [7:0] c);
        return c == CMD_STATUS_READ || c == CMD_FREQ_READ;
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift    <= 8'h00;
            bit_cnt  <= 3'h0;
            byte_cnt <= 2'h0;
            cmd      <= 8'h00;
        end else if (clk_en) begin
            if (!active) begin
                bit_cnt  <= 3'h0;
                byte_cnt <= 2'h0;
            end else if (rise) begin
                shift   <= next_byte;
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    if (byte_cnt != 2'h3)
                        byte_cnt <= byte_cnt + 2'h1;
                    if (byte_cnt == 2'h0)
                        cmd <= next_byte;
                end
            end
        end
    end

    // first data byte of a two-byte write is the high byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            first_byte <= 8'h00;
        else if (clk_en && byte_done && byte_cnt == 2'h1)
            first_byte <= next_byte;
    end

    ////////////////////////////////////////////////////////////////
    wire logic cmd_byte  = byte_done && byte_cnt == 2'h0;
    wire logic data1     = byte_done && byte_cnt == 2'h1;
    wire logic data2     = byte_done && byte_cnt == 2'h2;
    wire logic gen_reset = cmd_byte && next_byte == CMD_GENERAL_RESET;
    wire logic st_read   = cmd_byte && next_byte == CMD_STATUS_READ;
    wire logic tmr_write = data1 && cmd == CMD_TIMER_WRITE;
    wire logic sil_write = data1 && cmd == CMD_SILENCE_WRITE;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control        <= CONTROL_RESET;
            silence_period <= PERIOD_RESET;
            tone_one       <= TONE_RESET;
            tone_two       <= TONE_RESET;
            timer_period   <= PERIOD_RESET;
            timer_reload   <= 1'b0;
        end else if (clk_en) begin
            timer_reload <= 1'b0;
            if (data1 && cmd == CMD_CONTROL_WRITE)
                control <= next_byte;
            if (sil_write)
                silence_period <= next_byte;
            if (data2 && cmd == CMD_TONE1_WRITE)
                tone_one <= {first_byte, next_byte};
            if (data2 && cmd == CMD_TONE2_WRITE)
                tone_two <= {first_byte, next_byte};
            if (tmr_write) begin
                timer_period <= next_byte;
                timer_reload <= 1'b1;
            end
            if (gen_reset) begin
                timer_period <= PERIOD_RESET;
                timer_reload <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            audio_switch   <= 1'b0;
            summing_switch <= 1'b0;
            band_select    <= 2'h0;
        end else if (clk_en) begin
            audio_switch   <= control[CTL_AUDIO_SW];
            summing_switch <= control[CTL_SUM_SW];
            band_select    <= control[CTL_BAND_HI:CTL_BAND_LO];
        end
    end

    ////////////////////////////////////////////////////////////////
    // set wins over clear; a zero period expires until a nonzero period is written
    wire logic tmr_event = timer_expired || (timer_period == 8'h00 && !tmr_write);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            flags <= 3'h0;
        else if (clk_en) begin
            flags[ST_TIMER] <= tmr_event ? 1'b1 :
                (st_read || tmr_write || gen_reset) ? 1'b0 : flags[ST_TIMER];
            flags[ST_SILENCE] <= silence_expired ? 1'b1 :
                (st_read || sil_write || gen_reset) ? 1'b0 : flags[ST_SILENCE];
            flags[ST_MEASURE] <= measure_done ? 1'b1 :
                (st_read || gen_reset) ? 1'b0 : flags[ST_MEASURE];
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reply_shift    <= 16'h0000;
            bus.reply_data <= 1'b0;
        end else if (clk_en) begin
            if (cmd_byte && is_read(next_byte)) begin
                if (next_byte == CMD_STATUS_READ)
                    reply_shift <= {status_byte, 8'h00};
                else
                    reply_shift <= measured_freq;
            end else if (active && fall && byte_cnt != 2'h0 && is_read(cmd)) begin
                bus.reply_data <= reply_shift[15];
                reply_shift    <= {reply_shift[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            bus.irq_n <= 1'b1;
        else if (clk_en)
            bus.irq_n <= ~((flags[ST_TIMER] && control[CTL_TIMER_IEN]) ||
                ((flags[ST_SILENCE] || flags[ST_MEASURE]) && control[CTL_DEC_IEN]));
    end
endmodule
`default_nettype wire

// File: src/tone_bus_pkg.sv
`default_nettype none
package tone_bus_pkg;
    localparam logic [7:0] CMD_GENERAL_RESET = 8'h01;
    localparam logic [7:0] CMD_CONTROL_WRITE = 8'h30;
    localparam logic [7:0] CMD_STATUS_READ   = 8'h31;
    localparam logic [7:0] CMD_FREQ_READ     = 8'h32;
    localparam logic [7:0] CMD_SILENCE_WRITE = 8'h33;
    localparam logic [7:0] CMD_TONE1_WRITE   = 8'h34;
    localparam logic [7:0] CMD_TONE2_WRITE   = 8'h35;
    localparam logic [7:0] CMD_TIMER_WRITE   = 8'h36;
    // control bit positions
    localparam int CTL_AUDIO_SW   = 7;
    localparam int CTL_TIMER_IEN  = 6;
    localparam int CTL_DEC_IEN    = 5;
    localparam int CTL_SUM_SW     = 4;
    localparam int CTL_BAND_HI    = 3;
    localparam int CTL_BAND_LO    = 2;
    // status bit positions
    localparam int ST_LOGIC_IN    = 3;
    localparam int ST_TIMER       = 2;
    localparam int ST_SILENCE     = 1;
    localparam int ST_MEASURE     = 0;
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  PERIOD_RESET  = 8'h00;
    localparam logic [15:0] TONE_RESET    = 16'h0000;
    // host-side register offsets on ahb-lite
    localparam logic [7:0] HOST_CMD    = 8'h00;
    localparam logic [7:0] HOST_DATA   = 8'h04;
    localparam logic [7:0] HOST_STATUS = 8'h08;
    localparam logic [7:0] HOST_REPLY  = 8'h0c;
    localparam int HOST_DIV = 4;
endpackage
`default_nettype wire

// File: src/tone_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tone_bus_if;
    logic serial_clock;
    logic select_n;
    logic cmd_data;
    logic reply_data;
    logic irq_n;
    modport device (input serial_clock, input select_n, input cmd_data,
                    output reply_data, output irq_n);
    modport host   (output serial_clock, output select_n, output cmd_data,
                    input reply_data, input irq_n);
endinterface
`default_nettype wire

// File: src/tone_host.sv
`timescale 1ns/1ps
`default_nettype none
module tone_host
    import tone_bus_pkg::*;
#(
    parameter int DIV = HOST_DIV
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    tone_bus_if.host         bus
);
    import tone_bus_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_LOW  = 3'b010,
        S_HIGH = 3'b100
    } state_t;

    ////////////////////////////////////////////////////////////////
    logic       wr_pend;
    logic [7:0] ph_addr;
    logic [7:0] cmd_reg;
    logic [15:0] data_reg;
    logic [1:0] reply_s;
    logic [1:0] data_count;
    logic       busy, irq_s0, irq_s1;
    logic [15:0] reply;
    state_t     state;
    logic [2:0] bit_cnt;
    logic [1:0] byte_left;
    logic [7:0] tx;
    logic [$clog2(DIV)-1:0] div_cnt;
    wire logic start = wr_pend && ph_addr == HOST_CMD && hwdata[8];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            ph_addr <= 8'h00;
        end else if (clk_en) begin
            wr_pend <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1])
                ph_addr <= haddr[7:0];
        end
    end

    // cmd register: [7:0] command, [10:9] data byte count, [8] write also starts
    // data register: [15:8] first of two data bytes, [7:0] the last data byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_reg    <= 8'h00;
            data_reg   <= 16'h0000;
            data_count <= 2'h0;
        end else if (clk_en && wr_pend && !busy) begin
            if (ph_addr == HOST_CMD) begin
                cmd_reg    <= hwdata[7:0];
                data_count <= hwdata[10:9];
            end
            if (ph_addr == HOST_DATA)
                data_reg <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            irq_s0    <= 1'b1;
            irq_s1    <= 1'b1;
            reply_s   <= 2'h0;
        end else if (clk_en) begin
            irq_s0  <= bus.irq_n;
            irq_s1  <= irq_s0;
            reply_s <= {reply_s[0], bus.reply_data};
            if (hsel && hready && htrans[1] && !hwrite) begin
                unique case (haddr[7:0])
                    HOST_STATUS: hrdata <= {30'h0, ~irq_s1, busy};
                    HOST_REPLY:  hrdata <= {16'h0, reply};
                    HOST_CMD:    hrdata <= {24'h0, cmd_reg};
                    HOST_DATA:   hrdata <= {16'h0, data_reg};
                    default:     hrdata <= 32'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // shifts msb first; the host drives the clock by dividing hclk
    wire logic tick = div_cnt == $clog2(DIV)'(DIV - 1);
    wire logic [7:0] next_tx = (byte_left == 2'h2) ? data_reg[15:8] : data_reg[7:0];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state            <= S_IDLE;
            busy             <= 1'b0;
            div_cnt          <= '0;
            bit_cnt          <= 3'h0;
            byte_left        <= 2'h0;
            tx               <= 8'h00;
            reply            <= 16'h0000;
            bus.serial_clock <= 1'b0;
            bus.select_n     <= 1'b1;
            bus.cmd_data     <= 1'b0;
        end else if (clk_en) begin
            div_cnt <= tick ? '0 : div_cnt + 1'b1;
            unique case (state)
                S_IDLE: begin
                    if (start && !busy) begin
                        busy         <= 1'b1;
                        tx           <= hwdata[7:0];
                        byte_left    <= hwdata[10:9];
                        bit_cnt      <= 3'h0;
                        bus.select_n <= 1'b0;
                        bus.cmd_data <= hwdata[7];
                        div_cnt      <= '0;
                        state        <= S_LOW;
                    end
                end
                S_LOW: if (tick) begin
                    bus.serial_clock <= 1'b1;
                    state            <= S_HIGH;
                end
                S_HIGH: if (tick) begin
                    bus.serial_clock <= 1'b0;
                    reply   <= {reply[14:0], reply_s[1]};
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7) begin
                        if (byte_left == 2'h0) begin
                            bus.select_n <= 1'b1;
                            busy         <= 1'b0;
                            state        <= S_IDLE;
                        end else begin
                            byte_left    <= byte_left - 2'h1;
                            tx           <= next_tx;
                            bus.cmd_data <= next_tx[7];
                            state        <= S_LOW;
                        end
                    end else begin
                        tx           <= {tx[6:0], 1'b0};
                        bus.cmd_data <= tx[6];
                        state        <= S_LOW;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: dv/tone_bus_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tone_bus_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic serial_clock,
    input wire logic select_n,
    input wire logic cmd_data,
    input wire logic reply_data,
    input wire logic irq_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       sc_q;
    logic [5:0] rises;
    ////////////////////////////////////////////////////////////////
    // serial clock rises counted within one frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sc_q  <= 1'b0;
            rises <= 6'h00;
        end else begin
            sc_q <= serial_clock;
            if (select_n) begin
                rises <= 6'h00;
            end else if (serial_clock && !sc_q) begin
                rises <= rises + 6'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence high_phase;
        serial_clock [*4] ##1 !serial_clock;
    endsequence
    sequence frame_open;
        !select_n [*8];
    endsequence
    a_clock_high_time: assert property ($rose(serial_clock) |-> high_phase)
        else $error("serial clock high phase wrong");
    a_rise_in_frame: assert property ($rose(serial_clock) |-> !select_n)
        else $error("serial clock edge outside frame");
    a_idle_clock_low: assert property (select_n && $past(select_n) |-> !serial_clock)
        else $error("serial clock not low when idle");
    a_frame_whole_bytes: assert property ($rose(select_n) |-> rises inside {8, 16, 24})
        else $error("frame not a whole number of bytes");
    a_frame_min_len: assert property ($fell(select_n) |-> frame_open)
        else $error("frame closed too early");
    a_cmd_stable_high: assert property (serial_clock && $past(serial_clock) |-> $stable(cmd_data))
        else $error("command data moved while clock high");
    a_irq_clear_frame: assert property ($rose(irq_n) |-> !select_n || !$past(select_n)
        || !$past(select_n, 2) || !$past(select_n, 3))
        else $error("interrupt released outside a frame");
    a_irq_after_reset: assert property ($rose(hresetn) |-> irq_n ##1 irq_n)
        else $error("interrupt active after reset");
endmodule
`default_nettype wire

// File: dv/tone_processor_command_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tone_processor_command_status_bench;
    import tone_bus_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic [2:0]  ev_in = 3'b000;
    logic        logic_input = 1'b0;
    logic [15:0] measured_freq = 16'h0000;
    logic        audio_switch;
    logic        summing_switch;
    logic [1:0]  band_select;
    logic [7:0]  silence_period;
    logic [7:0]  timer_period;
    logic [15:0] tone_one;
    logic [15:0] tone_two;
    logic [31:0] rd;
    logic        hresp;
    logic        timer_reload;
    int          errors = 0;
    int          check_count = 0;
    int          reloads = 0;
    int          cycles = 0;
    always #20 hclk = ~hclk;
    tone_bus_if bus ();
    tone_host u_tone_host (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus(bus));
    tone_device u_tone_device (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .bus(bus),
        .logic_input(logic_input), .timer_expired(ev_in[2]), .silence_expired(ev_in[1]),
        .measure_done(ev_in[0]), .measured_freq(measured_freq), .audio_switch(audio_switch),
        .summing_switch(summing_switch), .band_select(band_select),
        .silence_period(silence_period), .tone_one(tone_one), .tone_two(tone_two),
        .timer_period(timer_period), .timer_reload(timer_reload));
    always @(posedge hclk) begin
        if (timer_reload === 1'b1) reloads++;
    end
    tone_bus_chk chk (.hclk(hclk), .hresetn(hresetn), .serial_clock(bus.serial_clock),
        .select_n(bus.select_n), .cmd_data(bus.cmd_data), .reply_data(bus.reply_data),
        .irq_n(bus.irq_n));
    ////////////////////////////////////////////////////////////////
    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            report_and_stop();
        end
    end
    // one ahb-lite single transfer, entered just after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // two-byte writes send d[15:8] first
    task automatic send(input logic [7:0] c, input logic [1:0] n, input logic [15:0] d);
        ahb(1'b1, HOST_DATA, {16'h0, d});
        ahb(1'b1, HOST_CMD, {21'h0, n, 1'b1, c});
        repeat (2) @(posedge hclk);
        rd = 32'h1;
        while (rd[0] !== 1'b0) ahb(1'b0, HOST_STATUS, 32'h0);
        repeat (8) @(posedge hclk);
    endtask
    task automatic run(input logic [7:0] c, input logic [1:0] n, input logic [7:0] d);
        send(c, n, {d, d});
    endtask
    task automatic ev(input logic [2:0] m);
        ev_in <= m;
        @(posedge hclk);
        ev_in <= 3'b000;
        repeat (4) @(posedge hclk);
    endtask
    task automatic status_is(input logic [7:0] exp);
        run(CMD_STATUS_READ, 2'd1, 8'h00);
        ahb(1'b0, HOST_REPLY, 32'h0);
        chk_val("status", {8'h00, exp}, {8'h00, rd[7:0]});
        chk_bit("hresp", 1'b0, hresp);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_control;
        logic [7:0] tbl [3] = '{8'h98, 8'h04, 8'h80};
        foreach (tbl[i]) begin
            run(CMD_CONTROL_WRITE, 2'd1, tbl[i]);
            chk_bit("audio", tbl[i][7], audio_switch);
            chk_bit("sum", tbl[i][4], summing_switch);
            chk_val("band", {14'h0, tbl[i][3:2]}, {14'h0, band_select});
        end
        chk_bit("irq", 1'b1, bus.irq_n);
    endtask
    task automatic t_timer;
        chk_val("period", 16'h0000, {8'h00, timer_period});
        run(CMD_CONTROL_WRITE, 2'd1, 8'h40);
        chk_bit("irq", 1'b0, bus.irq_n);
        run(CMD_TIMER_WRITE, 2'd1, 8'h55);
        chk_val("period", 16'h0055, {8'h00, timer_period});
        chk_bit("irq", 1'b1, bus.irq_n);
        ev(3'b100);
        chk_bit("irq", 1'b0, bus.irq_n);
        ahb(1'b0, HOST_STATUS, 32'h0);
        chk_bit("irq_flag", 1'b1, rd[1]);
        status_is(8'h04);
        chk_bit("irq", 1'b1, bus.irq_n);
    endtask
    task automatic t_decoder;
        run(CMD_CONTROL_WRITE, 2'd1, 8'h20);
        ev(3'b100);
        chk_bit("irq", 1'b1, bus.irq_n);
        ev(3'b010);
        chk_bit("irq", 1'b0, bus.irq_n);
        run(CMD_SILENCE_WRITE, 2'd1, 8'h7e);
        chk_val("silence", 16'h007e, {8'h00, silence_period});
        chk_bit("irq", 1'b1, bus.irq_n);
        ev(3'b001);
        run(CMD_SILENCE_WRITE, 2'd1, 8'h11);
        chk_bit("irq", 1'b0, bus.irq_n);
        logic_input <= 1'b1;
        status_is(8'h0d);
        chk_bit("irq", 1'b1, bus.irq_n);
        status_is(8'h08);
    endtask
    task automatic t_data;
        measured_freq <= 16'ha5c3;
        ev(3'b001);
        run(CMD_FREQ_READ, 2'd2, 8'h00);
        ahb(1'b0, HOST_REPLY, 32'h0);
        chk_val("freq", 16'ha5c3, rd[15:0]);
        send(CMD_TONE1_WRITE, 2'd2, 16'h3cc3);
        send(CMD_TONE2_WRITE, 2'd2, 16'h5aa5);
        chk_val("tone1", 16'h3cc3, tone_one);
        chk_val("tone2", 16'h5aa5, tone_two);
    endtask
    task automatic t_greset;
        int base;
        base = reloads;
        run(CMD_GENERAL_RESET, 2'd0, 8'h00);
        chk_val("period", 16'h0000, {8'h00, timer_period});
        run(CMD_CONTROL_WRITE, 2'd1, 8'h40);
        chk_bit("irq", 1'b0, bus.irq_n);
        run(CMD_CONTROL_WRITE, 2'd1, 8'h00);
        run(CMD_TIMER_WRITE, 2'd1, 8'h21);
        run(CMD_CONTROL_WRITE, 2'd1, 8'h40);
        chk_val("period", 16'h0021, {8'h00, timer_period});
        chk_bit("irq", 1'b1, bus.irq_n);
        chk_val("reloads", 16'(base + 2), 16'(reloads));
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_bit("irq", 1'b1, bus.irq_n);
        t_control();
        t_timer();
        t_decoder();
        t_data();
        t_greset();
        report_and_stop();
    end
endmodule
`default_nettype wire
